// ### rtl/alert_qual_pkg.sv
package alert_qual_pkg;

  // Register offsets on the 24-bit register port
  localparam logic [7:0]  ADDR_UV_QUAL    = 8'h48;     // Undervoltage sample-count byte
  localparam logic [7:0]  ADDR_ALERT_EN   = 8'h49;     // Alert source enables (written copy)
  localparam logic [7:0]  ADDR_EN_ACTIVE  = 8'h4c;     // Enables currently in force
  localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h4d;     // Sticky alert events, cleared by read
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h4e;     // Interrupt mask, same layout

  // Values after reset
  localparam logic [7:0]  RST_UV_QUAL     = 8'h00;
  localparam logic [23:0] RST_ALERT_EN    = 24'h000000;
  localparam logic [23:0] RST_IRQ_MASK    = 24'h000000;

  // Field positions inside the enable register; channel 1 is the top bit of each nibble
  localparam int          POS_OVERCURRENT  = 20;
  localparam int          POS_UNDERCURRENT = 16;
  localparam int          POS_OVERVOLTAGE  = 12;
  localparam int          POS_UNDERVOLTAGE = 8;
  localparam int          POS_OVERPOWER    = 4;
  localparam int          POS_ACCUM_OVF    = 3;
  localparam int          POS_ACCUM_COUNT  = 2;
  localparam int          POS_CONV_DONE    = 1;

  // Bit 0 is unimplemented
  localparam logic [23:0] EN_IMPL_MASK    = 24'hfffffe;

  // Sample-count codes and the counts they stand for
  localparam logic [1:0]  QUAL_CODE_1     = 2'h0;
  localparam logic [1:0]  QUAL_CODE_4     = 2'h1;
  localparam logic [1:0]  QUAL_CODE_8     = 2'h2;
  localparam logic [1:0]  QUAL_CODE_16    = 2'h3;
  localparam logic [4:0]  QUAL_COUNT_1    = 5'h01;
  localparam logic [4:0]  QUAL_COUNT_4    = 5'h04;
  localparam logic [4:0]  QUAL_COUNT_8    = 5'h08;
  localparam logic [4:0]  QUAL_COUNT_16   = 5'h10;

  // Decode a two-bit sample-count code into a count
  function automatic logic [4:0] uv_threshold(input logic [1:0] code);
    logic [4:0] n;
    n = QUAL_COUNT_1;
    unique case (code)
      QUAL_CODE_1:  n = QUAL_COUNT_1;
      QUAL_CODE_4:  n = QUAL_COUNT_4;
      QUAL_CODE_8:  n = QUAL_COUNT_8;
      QUAL_CODE_16: n = QUAL_COUNT_16;
    endcase
    return n;
  endfunction

endpackage

// ### rtl/uv_qualifier.sv
`timescale 1ns/10ps
`default_nettype none
module uv_qualifier
  import alert_qual_pkg::*;
(
  input  wire logic       clk,        // Block clock
  input  wire logic       srst,       // Synchronous reset, high
  input  wire logic       sample,     // One-cycle pulse per completed sample
  input  wire logic [3:0] below,      // Sample breaches the limit, bit 3 is channel 1
  input  wire logic [7:0] count_sel,  // Sample-count byte, channel 1 in the top pair
  output logic      [3:0] uv_alert    // Qualified undervoltage, level
);

  // All state of the qualifier
  typedef struct packed {
    logic [3:0][4:0] cnt;             // Consecutive breach counters
    logic [3:0]      alert;           // Qualified flags
  } qual_s;

  qual_s st_q;
  qual_s st_d;

  // Counters saturate at sixteen so a long breach never wraps back to zero
  always_comb
  begin
    st_d = st_q;
    for (int i = 0; i < 4; i++)
    begin
      if (sample && below[i])
      begin
        if (st_q.cnt[i] != QUAL_COUNT_16)
          st_d.cnt[i] = 5'(st_q.cnt[i] + 5'h01);
        st_d.alert[i] = (st_d.cnt[i] >= uv_threshold(count_sel[2*i +: 2])); // see R01 see R03
      end
      else if (sample)
      begin
        // A clean sample restarts the run and drops the alert
        st_d.cnt[i]   = 5'h00;  // see R16
        st_d.alert[i] = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (srst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign uv_alert = st_q.alert;

  // A clean sample on channel 1 clears its counter and flag
  chk_uv_restart: assert property (@(posedge clk) disable iff (srst) // see R16
    sample && !below[3] |=> st_q.cnt[3] == 5'h00 && !uv_alert[3])
    else $error("counter not restarted by clean sample");

  // A rising flag needs at least the selected run of breaches
  chk_uv_threshold: assert property (@(posedge clk) disable iff (srst) // see R03
    $rose(uv_alert[3]) |-> st_q.cnt[3] >= uv_threshold($past(count_sel[7:6])))
    else $error("alert raised before run complete");

  // With code one count, a single breach raises the flag
  chk_uv_single: assert property (@(posedge clk) disable iff (srst) // see R01
    sample && below[0] && count_sel[1:0] == QUAL_CODE_1 |=> uv_alert[0])
    else $error("single-sample alert missing");

endmodule
`default_nettype wire

// ### rtl/monitor_alert_qualify_enable.sv
// Notes on behaviour
// R01: Code 00,01,10,11 selects 1,4,8,16 samples
// R02: Channel 1 top pair, channel 4 bottom pair
// R03: Undervoltage alert after selected consecutive breaches
// R04: Software disables alerts before changing counts
// R05: Enable bits write 1 enable, reset zero
// R06: Overcurrent bits 23-20, undercurrent bits 19-16
// R07: Overvoltage bits 15-12, undervoltage bits 11-8
// R08: Overpower enables in bits 7-4
// R09: Bit 3 enables accumulator overflow alert
// R10: Bit 2 enables sample count full alert
// R11: Bit 1 enables conversion complete alert
// R12: Bit 0 ignores writes, reads zero
// R13: Alert passes only while enabled
// R14: New enables take effect at refresh
// R15: Software disables alerts before changing limits
// R16: Clean sample restarts the breach counter
`timescale 1ns/10ps
`default_nettype none
module monitor_alert_qualify_enable
  import alert_qual_pkg::*;
(
  input  wire logic        MCLK,           // 40 MHz block clock
  input  wire logic        SRST,           // Synchronous reset, high
  input  wire logic [7:0]  ADDR,           // Register address
  input  wire logic [23:0] WDATA,          // Write data
  input  wire logic        WR,             // Write strobe
  input  wire logic        RD,             // Read strobe
  output logic      [23:0] RDATA,          // Read data, valid the cycle after RD
  input  wire logic        SAMPLE_VALID,   // Conversion cycle complete, one-cycle pulse
  input  wire logic [3:0]  OC_HIT,         // Overcurrent per channel, bit 3 is channel 1
  input  wire logic [3:0]  UC_HIT,         // Undercurrent per channel
  input  wire logic [3:0]  OV_HIT,         // Overvoltage per channel
  input  wire logic [3:0]  UV_BREACH,      // Sample breaches undervoltage limit
  input  wire logic [3:0]  OP_HIT,         // Overpower per channel
  input  wire logic        EN_ACCUM_OVERFLOW_HIT,    // Accumulator fullness exceeded on some channel
  input  wire logic        EN_ACCUM_COUNT_FULL_HIT,  // Accumulation sample counter full
  input  wire logic        REFRESH,        // Refresh command executed, any variant
  output logic      [23:0] ALERT_SRC,      // Enabled alert sources for pin routing
  output logic             IRQ             // Level interrupt
);

  // All state of the block
  typedef struct packed {
    logic [7:0]  uv_cfg;                   // Sample-count byte
    logic [23:0] en_pend;                  // Enables as written
    logic [23:0] en_act;                   // Enables in force
    logic [23:0] alert;                    // Gated alert sources
    logic [23:0] status;                   // Sticky alert events
    logic [23:0] mask;                     // Interrupt mask
    logic [23:0] rdata;                    // Read data register
  } main_s;

  localparam main_s ST_RST = '{
    uv_cfg:  RST_UV_QUAL,
    en_pend: RST_ALERT_EN,
    en_act:  RST_ALERT_EN,
    alert:   24'h000000,
    status:  24'h000000,
    mask:    RST_IRQ_MASK,
    rdata:   24'h000000
  };

  main_s       st_q;                       // Registered state
  main_s       st_d;                       // Next state
  logic [3:0]  uv_lvl;                     // Qualified undervoltage per channel
  logic [23:0] raw;                        // Ungated sources captured at a sample
  logic [23:0] rise;                       // Alert bits that just came up

  // Undervoltage qualification runs per channel on the sample-count byte
  uv_qualifier u_uv_qual (
    .clk       (MCLK),
    .srst      (SRST),
    .sample    (SAMPLE_VALID),
    .below     (UV_BREACH),
    .count_sel (st_q.uv_cfg),              // see R02
    .uv_alert  (uv_lvl)
  );

  // Place each raw source except undervoltage at its enable bit
  always_comb
  begin
    raw = 24'h000000;
    raw[POS_OVERCURRENT  +: 4] = OC_HIT;   // see R06
    raw[POS_UNDERCURRENT +: 4] = UC_HIT;   // see R06
    raw[POS_OVERVOLTAGE  +: 4] = OV_HIT;   // see R07
    raw[POS_OVERPOWER    +: 4] = OP_HIT;   // see R08
    raw[POS_ACCUM_OVF]         = EN_ACCUM_OVERFLOW_HIT;    // see R09
    raw[POS_ACCUM_COUNT]       = EN_ACCUM_COUNT_FULL_HIT;  // see R10
    raw[POS_CONV_DONE]         = 1'b1;           // see R11
  end

  // Next-state logic for registers, alert gating and interrupt status
  always_comb
  begin
    st_d = st_q;

    // Register writes
    if (WR)
    begin
      unique case (ADDR)
        ADDR_UV_QUAL:
          st_d.uv_cfg = WDATA[7:0];                 // see R01
        ADDR_ALERT_EN:
          st_d.en_pend = WDATA & EN_IMPL_MASK;      // see R05 see R12
        ADDR_IRQ_MASK:
          st_d.mask = WDATA & EN_IMPL_MASK;
        default:
          // Read-only and unmapped addresses ignore writes
          st_d.en_pend = st_q.en_pend;
      endcase
    end

    // A refresh copies written enables into force; until then they wait
    if (REFRESH)
      st_d.en_act = st_q.en_pend;                   // see R14

    // Level sources hold between samples; conversion done is one cycle wide
    if (SAMPLE_VALID)
      st_d.alert = raw & st_q.en_act;               // see R13
    else
      st_d.alert = st_q.alert & ~(24'h000001 << POS_CONV_DONE) & st_q.en_act;

    // Undervoltage follows its qualifier, one cycle behind the sample
    st_d.alert[POS_UNDERVOLTAGE +: 4] = uv_lvl & st_q.en_act[POS_UNDERVOLTAGE +: 4]; // see R03 see R07

    // Events are alert bits coming up in this cycle; kept in this process so no loop crosses processes
    rise = st_d.alert & ~st_q.alert;

    // Read data; unmapped addresses answer zero
    if (RD)
    begin
      unique case (ADDR)
        ADDR_UV_QUAL:    st_d.rdata = {16'h0000, st_q.uv_cfg};
        ADDR_ALERT_EN:   st_d.rdata = st_q.en_pend & EN_IMPL_MASK;  // see R12
        ADDR_EN_ACTIVE:  st_d.rdata = st_q.en_act;
        ADDR_IRQ_STATUS: st_d.rdata = st_q.status;
        ADDR_IRQ_MASK:   st_d.rdata = st_q.mask;
        default:         st_d.rdata = 24'h000000;
      endcase
    end

    // Reading status clears it, but a new event in the same cycle survives
    if (RD && ADDR == ADDR_IRQ_STATUS)
      st_d.status = rise;
    else
      st_d.status = st_q.status | rise;
  end

  // State register
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      st_q <= ST_RST;
    else
      st_q <= st_d;
  end

  // Outputs come straight from state
  assign RDATA     = st_q.rdata;
  assign ALERT_SRC = st_q.alert;            // see R13
  assign IRQ       = |(st_q.status & st_q.mask);

  // Unimplemented bit reads zero whatever was written
  chk_bit0_zero: assert property (@(posedge MCLK) disable iff (SRST) // see R12
    RD && ADDR == ADDR_ALERT_EN |=> RDATA[0] == 1'b0)
    else $error("unimplemented enable bit read as one");

  // Enable write lands in the written copy only
  chk_enable_write: assert property (@(posedge MCLK) disable iff (SRST) // see R05
    WR && ADDR == ADDR_ALERT_EN |=> st_q.en_pend == ($past(WDATA) & EN_IMPL_MASK))
    else $error("enable write not stored");

  // Enables in force change only through a refresh
  chk_active_hold: assert property (@(posedge MCLK) disable iff (SRST) // see R14
    !REFRESH |=> $stable(st_q.en_act))
    else $error("active enables changed without refresh");

  // Refresh brings in the written copy
  chk_refresh_load: assert property (@(posedge MCLK) disable iff (SRST) // see R14
    REFRESH |=> st_q.en_act == $past(st_q.en_pend))
    else $error("refresh did not activate enables");

  // No alert stands without its enable
  chk_gate_enable: assert property (@(posedge MCLK) disable iff (SRST) // see R13
    ##1 (ALERT_SRC & ~$past(st_q.en_act)) == 24'h000000)
    else $error("alert passed while disabled");

  // Current alerts land at bits 23 to 16
  chk_current_field: assert property (@(posedge MCLK) disable iff (SRST) // see R06
    SAMPLE_VALID |=> ALERT_SRC[23:16] == ($past({OC_HIT, UC_HIT}) & $past(st_q.en_act[23:16])))
    else $error("current alert misplaced");

  // Overvoltage alerts land at bits 15 to 12
  chk_volt_field: assert property (@(posedge MCLK) disable iff (SRST) // see R07
    SAMPLE_VALID |=> ALERT_SRC[15:12] == ($past(OV_HIT) & $past(st_q.en_act[15:12])))
    else $error("overvoltage alert misplaced");

  // Overpower alerts land at bits 7 to 4
  chk_power_field: assert property (@(posedge MCLK) disable iff (SRST) // see R08
    SAMPLE_VALID |=> ALERT_SRC[7:4] == ($past(OP_HIT) & $past(st_q.en_act[7:4])))
    else $error("overpower alert misplaced");

  // Accumulator alerts land at bits 3 and 2
  chk_accum_bits: assert property (@(posedge MCLK) disable iff (SRST) // see R09 see R10
    SAMPLE_VALID |=> ALERT_SRC[3:2] == ($past({EN_ACCUM_OVERFLOW_HIT, EN_ACCUM_COUNT_FULL_HIT}) & $past(st_q.en_act[3:2])))
    else $error("accumulator alert misplaced");

  // Conversion done is a single-cycle alert following each sample
  chk_conv_done: assert property (@(posedge MCLK) disable iff (SRST) // see R11
    ##1 ALERT_SRC[1] == $past(SAMPLE_VALID && st_q.en_act[1]))
    else $error("conversion done alert wrong");

  // Qualified undervoltage reaches its bits when enabled
  chk_uv_route: assert property (@(posedge MCLK) disable iff (SRST) // see R03
    ##1 ALERT_SRC[11:8] == ($past(uv_lvl) & $past(st_q.en_act[11:8])))
    else $error("undervoltage alert not routed");

  // Sample-count byte takes the write
  chk_uv_cfg_write: assert property (@(posedge MCLK) disable iff (SRST) // see R02
    WR && ADDR == ADDR_UV_QUAL |=> st_q.uv_cfg == $past(WDATA[7:0]))
    else $error("sample-count byte not stored");

  // Reset clears both copies of the enables
  // Checked without the disable so the reset cycle itself is covered
  chk_reset_enables: assert property (@(posedge MCLK) // see R05
    SRST
    |=> st_q.en_pend == RST_ALERT_EN && st_q.en_act == RST_ALERT_EN)
    else $error("enables not cleared by reset");

  // Reset leaves no alert and no interrupt behind
  chk_reset_sources: assert property (@(posedge MCLK) // see R05
    SRST
    |=> ALERT_SRC == 24'h000000 && !IRQ)
    else $error("alert or interrupt survived reset");

  // Written enables change only through a write to their own address
  chk_pend_hold: assert property (@(posedge MCLK) disable iff (SRST) // see R05
    !(WR && ADDR == ADDR_ALERT_EN)
    |=> $stable(st_q.en_pend))
    else $error("written enables changed without write");

  // Bit 0 never holds a one in either copy
  // A stray one here would leak into the active set at the next refresh
  chk_bit0_store: assert property (@(posedge MCLK) disable iff (SRST) // see R12
    1'b1
    |-> !st_q.en_pend[0] && !st_q.en_act[0])
    else $error("unimplemented enable bit stored");

  // Reading the enable address returns the written copy
  chk_enable_read: assert property (@(posedge MCLK) disable iff (SRST) // see R05
    RD && ADDR == ADDR_ALERT_EN
    |=> RDATA == $past(st_q.en_pend))
    else $error("enable read returned wrong value");

  // Reading the active address returns the enables in force
  // Software uses it to see whether a refresh has happened yet
  chk_active_read: assert property (@(posedge MCLK) disable iff (SRST) // see R14
    RD && ADDR == ADDR_EN_ACTIVE
    |=> RDATA == $past(st_q.en_act))
    else $error("active enable read returned wrong value");

  // The active copy cannot be written directly
  chk_active_readonly: assert property (@(posedge MCLK) disable iff (SRST) // see R14
    WR && ADDR == ADDR_EN_ACTIVE && !REFRESH
    |=> $stable(st_q.en_act))
    else $error("active enables took a write");

  // Without a sample no level source may come up
  // Undervoltage is left out since its qualifier lags the sample by a cycle
  chk_level_hold: assert property (@(posedge MCLK) disable iff (SRST) // see R13
    !SAMPLE_VALID
    |=> (ALERT_SRC & ~$past(ALERT_SRC) & 24'hfff0fe) == 24'h000000)
    else $error("alert rose without a sample");

  // After a refresh only the newly activated set can pass
  // Two cycles: one to load the active copy, one to gate the sources
  chk_refresh_gate: assert property (@(posedge MCLK) disable iff (SRST) // see R14
    REFRESH
    |=> ##1 (ALERT_SRC & ~$past(st_q.en_pend, 2)) == 24'h000000)
    else $error("alert passed outside refreshed enables");

  // Sample-count byte reads back in the low byte, upper bits zero
  chk_uv_cfg_read: assert property (@(posedge MCLK) disable iff (SRST) // see R02
    RD && ADDR == ADDR_UV_QUAL
    |=> RDATA == {16'h0000, $past(st_q.uv_cfg)})
    else $error("sample-count byte read wrong");

  // Sample-count byte changes only by its own write
  // A silent change would alter the required run length behind software's back
  chk_uv_cfg_hold: assert property (@(posedge MCLK) disable iff (SRST) // see R01
    !(WR && ADDR == ADDR_UV_QUAL)
    |=> $stable(st_q.uv_cfg))
    else $error("sample-count byte changed without write");

  // Disabled undervoltage channels stay quiet whatever the qualifier says
  chk_uv_masked: assert property (@(posedge MCLK) disable iff (SRST) // see R07
    SAMPLE_VALID && st_q.en_act[11:8] == 4'h0 && !REFRESH
    |=> ##1 ALERT_SRC[11:8] == 4'h0)
    else $error("disabled undervoltage alert passed");

  // Every rising alert bit is recorded in status
  // Covers the clear-on-read cycle as well, where the new event must win
  chk_status_event: assert property (@(posedge MCLK) disable iff (SRST) // see R13
    ##1 (ALERT_SRC & ~$past(ALERT_SRC) & ~st_q.status) == 24'h000000)
    else $error("alert event missing from status");

  // Status bits stay set until status is read
  chk_status_sticky: assert property (@(posedge MCLK) disable iff (SRST) // see R13
    !(RD && ADDR == ADDR_IRQ_STATUS)
    |=> (~st_q.status & $past(st_q.status)) == 24'h000000)
    else $error("status bit lost without read");

  // A status read leaves only events of that same cycle
  // Older events are gone; software has just seen them in the read data
  chk_status_clear: assert property (@(posedge MCLK) disable iff (SRST) // see R13
    RD && ADDR == ADDR_IRQ_STATUS
    |=> st_q.status == (ALERT_SRC & ~$past(ALERT_SRC)))
    else $error("status not cleared by read");

  // Status read returns the events held before the clear
  chk_status_read: assert property (@(posedge MCLK) disable iff (SRST) // see R13
    RD && ADDR == ADDR_IRQ_STATUS
    |=> RDATA == $past(st_q.status))
    else $error("status read returned wrong value");

  // Mask write lands with bit 0 forced low
  // Keeps the mask layout identical to the enable layout
  chk_mask_write: assert property (@(posedge MCLK) disable iff (SRST) // see R12
    WR && ADDR == ADDR_IRQ_MASK
    |=> st_q.mask == ($past(WDATA) & EN_IMPL_MASK))
    else $error("mask write not stored");

  // An unmapped address reads zero
  // Software probing the map must not see stale data
  chk_unmapped_read: assert property (@(posedge MCLK) disable iff (SRST) // see R12
    RD && ADDR == 8'h50
    |=> RDATA == 24'h000000)
    else $error("unmapped read not zero");

endmodule
`default_nettype wire

// ### testbench/monitor_alert_qualify_enable_tb.sv
`timescale 1ns/10ps
`default_nettype none
module monitor_alert_qualify_enable_tb
  import alert_qual_pkg::*;
;
  // Stimulus side, every input given a value at time zero
  logic        MCLK          = 1'b0;
  logic        SRST          = 1'b1;
  logic        WR            = 1'b0;
  logic        RD            = 1'b0;
  logic        SAMPLE_VALID  = 1'b0;
  logic        REFRESH       = 1'b0;
  logic        EN_ACCUM_OVERFLOW_HIT   = 1'b0;
  logic        EN_ACCUM_COUNT_FULL_HIT = 1'b0;
  logic [7:0]  ADDR          = 8'h00;
  logic [23:0] WDATA         = 24'h000000;
  logic [3:0]  OC_HIT        = 4'h0;
  logic [3:0]  UC_HIT        = 4'h0;
  logic [3:0]  OV_HIT        = 4'h0;
  logic [3:0]  UV_BREACH     = 4'h0;
  logic [3:0]  OP_HIT        = 4'h0;
  // Observed side
  logic [23:0] RDATA;
  logic [23:0] ALERT_SRC;
  logic        IRQ;
  // Bookkeeping and captures
  int          err_count   = 0;
  int          comparisons = 0;
  logic [23:0] a1;            // Alert sources one cycle after a sample
  logic [23:0] a2;            // Alert sources two cycles after, UV path settled
  logic [23:0] rd;            // Last read data
  int          n;             // Consecutive samples needed
  logic [23:0] b;             // UV bit under test
  // Rows: enables, hit pattern in enable layout, expected sources
  typedef struct {logic [23:0] en; logic [23:0] hit; logic [23:0] exp;} row_s;
  row_s        rows[10] = '{'{24'hffffff, 24'hf00000, 24'hf00002}, '{24'hffffff, 24'h0f0000, 24'h0f0002},
                            '{24'hffffff, 24'h00f000, 24'h00f002}, '{24'hffffff, 24'h000f00, 24'h000f02},
                            '{24'hffffff, 24'h0000f0, 24'h0000f2}, '{24'hffffff, 24'h00000c, 24'h00000e},
                            '{24'h800000, 24'hfffffc, 24'h800000}, '{24'h000002, 24'h000000, 24'h000002},
                            '{24'h5a5a5a, 24'hfffffc, 24'h5a5a5a}, '{24'ha5a5a5, 24'hfffffc, 24'ha5a5a4}};
  logic [7:0]  regs[6] = '{ADDR_UV_QUAL, ADDR_ALERT_EN, ADDR_EN_ACTIVE, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, 8'h50};
  int          cnts[4] = '{1, 4, 8, 16};

  monitor_alert_qualify_enable DUT (
    .MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SAMPLE_VALID(SAMPLE_VALID), .OC_HIT(OC_HIT), .UC_HIT(UC_HIT), .OV_HIT(OV_HIT),
    .UV_BREACH(UV_BREACH), .OP_HIT(OP_HIT), .EN_ACCUM_OVERFLOW_HIT(EN_ACCUM_OVERFLOW_HIT), .EN_ACCUM_COUNT_FULL_HIT(EN_ACCUM_COUNT_FULL_HIT),
    .REFRESH(REFRESH), .ALERT_SRC(ALERT_SRC), .IRQ(IRQ));

  // 40 MHz clock
  always #12.5 MCLK = ~MCLK;

  // Compare a 24-bit result
  task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  // Compare the interrupt level
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: interrupt %b, expected %b", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge MCLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge MCLK);
    WR    <= 1'b0;
  endtask

  // One-cycle read strobe; data only stand in the following cycle
  task automatic rdreg(input logic [7:0] a, output logic [23:0] d);
    @(posedge MCLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge MCLK);
    RD   <= 1'b0;
    #1 d = RDATA;
  endtask

  // Refresh pulse makes written enables active
  task automatic refresh;
    @(posedge MCLK);
    REFRESH <= 1'b1;
    @(posedge MCLK);
    REFRESH <= 1'b0;
  endtask

  // One sample; hits stay as level afterwards, as the design latches them anyway
  task automatic smp(input logic [23:0] h);
    @(posedge MCLK);
    SAMPLE_VALID  <= 1'b1;
    OC_HIT        <= h[23:20];
    UC_HIT        <= h[19:16];
    OV_HIT        <= h[15:12];
    UV_BREACH     <= h[11:8];
    OP_HIT        <= h[7:4];
    EN_ACCUM_OVERFLOW_HIT   <= h[3];
    EN_ACCUM_COUNT_FULL_HIT <= h[2];
    @(posedge MCLK);
    SAMPLE_VALID  <= 1'b0;
    #1 a1 = ALERT_SRC;
    @(posedge MCLK);
    #1 a2 = ALERT_SRC;
  endtask

  // Single place where the run ends
  task automatic close_out;
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    repeat (100000) @(posedge MCLK);
    err_count++;
    $display("ERROR %0t: run did not finish", $time);
    close_out;
  end

  initial
  begin
    repeat (5) @(posedge MCLK);
    SRST <= 1'b0;
    #1 chk24(ALERT_SRC, 24'h000000);
    chk1(IRQ, 1'b0);
    // Every register and an unmapped place read zero after reset
    foreach (regs[i])
    begin
      rdreg(regs[i], rd);
      chk24(rd, 24'h000000);
    end
    // Table of field layouts; conversion-done pulses bit 1 with each sample
    foreach (rows[i])
    begin
      wr(ADDR_ALERT_EN, rows[i].en);
      refresh;
      rdreg(ADDR_ALERT_EN, rd);
      chk24(rd, rows[i].en & 24'hfffffe);
      smp(rows[i].hit);
      chk24(a1 & 24'hfff0fe, rows[i].exp & 24'hfff0fe);
      chk24(a2 & 24'h000f02, rows[i].exp & 24'h000f00);
    end
    // New enables stay dormant until refresh; active copy is read-only
    wr(ADDR_ALERT_EN, 24'hffffff);
    wr(ADDR_EN_ACTIVE, 24'h000000);
    smp(24'hfffffc);
    chk24(a1, 24'ha5a5a4);
    rdreg(ADDR_EN_ACTIVE, rd);
    chk24(rd, 24'ha5a5a4);
    refresh;
    rdreg(ADDR_EN_ACTIVE, rd);
    chk24(rd, 24'hfffffe);
    // Every code on every channel; a clean sample in mid-run restarts the count
    for (int ch = 0; ch < 4; ch++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        n = cnts[c];
        b = 24'h000800 >> ch;
        wr(ADDR_ALERT_EN, 24'h000000);
        refresh;
        wr(ADDR_UV_QUAL, 24'(c) << (6 - 2 * ch));
        wr(ADDR_ALERT_EN, 24'hffffff);
        refresh;
        smp(24'h000000);
        repeat (n - 1) smp(b);
        smp(24'h000000);
        repeat (n - 1) smp(b);
        chk24(a2 & 24'h000f00, 24'h000000);
        smp(b);
        chk24(a2 & 24'h000f00, b);
      end
    end
    // Interrupt: raise while masked, unmask, clear by reading status
    smp(24'h000000);
    rdreg(ADDR_IRQ_STATUS, rd);
    smp(24'h800000);
    chk1(IRQ, 1'b0);
    wr(ADDR_IRQ_MASK, 24'h800001);
    rdreg(ADDR_IRQ_MASK, rd);
    chk24(rd, 24'h800000);
    chk1(IRQ, 1'b1);
    rdreg(ADDR_IRQ_STATUS, rd);
    chk24(rd, 24'h800002);
    chk1(IRQ, 1'b0);
    // Second reset in mid-run clears everything again
    @(posedge MCLK);
    SRST <= 1'b1;
    repeat (2) @(posedge MCLK);
    SRST <= 1'b0;
    #1 chk24(ALERT_SRC, 24'h000000);
    chk1(IRQ, 1'b0);
    rdreg(ADDR_ALERT_EN, rd);
    chk24(rd, 24'h000000);
    close_out;
  end
endmodule
`default_nettype wire
